//--- core/optseq_pkg.sv
// Shared constants and types for the sample sequencer and its host controller
package optseq_pkg;

	// ----------------------------------------
	// Clocking and time bases
	// ----------------------------------------
	localparam int CLK_HZ = 100000000; // System clock rate
	localparam int CLK_NS = 10; // System clock period
	localparam int SCLK_HZ = 32000; // Sample-rate clock rate
	localparam int SCLK_NS = 31250; // Sample-rate clock period
	localparam int SCLK_DIV = CLK_HZ / SCLK_HZ; // System cycles per sample tick
	localparam logic [12:0] SCLK_DIV_W = 13'(SCLK_DIV); // Divider at counter width
	localparam logic [12:0] TRIM_MID = 13'h0020; // Trim code that adds nothing
	localparam int PROC_A_NS = 68000; // Processing after first slot
	localparam int PROC_B_NS = 20000; // Processing after second slot
	localparam logic [1:0] PROC_A_TICKS = 2'((PROC_A_NS + SCLK_NS - 1) / SCLK_NS);
	localparam logic [1:0] PROC_B_TICKS = 2'((PROC_B_NS + SCLK_NS - 1) / SCLK_NS);
	localparam logic [1:0] SLOT_TICKS = 2'h2; // Pulse window of one slot

	// ----------------------------------------
	// Device register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_MODE = 8'h10;
	localparam logic [7:0] ADDR_RATE = 8'h12;
	localparam logic [7:0] ADDR_ROUTE = 8'h14;
	localparam logic [7:0] ADDR_PULSE_A = 8'h30;
	localparam logic [7:0] ADDR_PULSE_B = 8'h35;
	localparam logic [7:0] ADDR_TRIG = 8'h38;
	localparam logic [7:0] ADDR_WIN_A = 8'h39;
	localparam logic [7:0] ADDR_WIN_B = 8'h3b;
	localparam logic [7:0] ADDR_OSC = 8'h4b;
	localparam logic [7:0] ADDR_PIN = 8'h4f;

	// ----------------------------------------
	// Field positions and codes
	// ----------------------------------------
	localparam int MODE_LSB = 0; // Mode field [1:0]
	localparam int SLOT_A_EN_BIT = 2; // First slot enable
	localparam int SLOT_B_EN_BIT = 3; // Second slot enable
	localparam int ROUTE_A_LSB = 4; // First slot route [7:4]
	localparam int ROUTE_B_LSB = 8; // Second slot route [11:8]
	localparam int TRIM_LSB = 0; // Oscillator trim [5:0]
	localparam int CLKSEL_LSB = 7; // Clock source [8:7]
	localparam int PIN0_BUF_BIT = 1; // Pin zero input buffer
	localparam int SYNCSEL_LSB = 2; // Sync source [3:2]
	localparam int PIN1_CFG_LSB = 5; // Pin one config [6:5]
	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_PROGRAM = 2'h1;
	localparam logic [1:0] MODE_NORMAL = 2'h2;
	localparam logic [1:0] CLKSEL_EXT = 2'h2;
	localparam logic [1:0] SYNC_PIN0 = 2'h1;
	localparam logic [1:0] SYNC_PIN1 = 2'h2;
	localparam logic [1:0] PIN1_INPUT = 2'h1;
	localparam logic [3:0] ROUTE_FLOAT = 4'h0;
	localparam logic [3:0] ROUTE_SUM = 4'h1;
	localparam logic [3:0] ROUTE_SPLIT = 4'h5;

	// ----------------------------------------
	// Reset and recommended values
	// ----------------------------------------
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [15:0] TRIG_EXT_SYNC = 16'h4000;
	localparam logic [15:0] PULSE_RECOMMEND = 16'h0320;
	localparam logic [15:0] WINDOW_RECOMMEND = 16'h22f0;

	// ----------------------------------------
	// Host APB register offsets
	// ----------------------------------------
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_PINGEN = 8'h08;
	localparam logic [3:0] SETUP_STEPS = 4'h8;

	// Sequencer states
	typedef enum logic [2:0] {SEQ_SLEEP, SEQ_SLOT_A, SEQ_PROC_A, SEQ_SLOT_B, SEQ_PROC_B} seq_state_t;

endpackage

//--- core/optseq_if.sv
// Link between host controller and sample sequencer: register port and general pins
`timescale 1ns/1ps
`default_nettype none
interface optseq_if;
	logic reg_req; // Host holds until acknowledged
	logic reg_wr; // 1 write, 0 read
	logic [7:0] reg_addr; // Device register offset
	logic [15:0] reg_wdata; // Write data
	logic [15:0] reg_rdata; // Read data, valid with ack
	logic reg_ack; // One-cycle answer
	logic pin_zero_o; // Host level on pin zero
	logic pin_zero_oe; // Host drives pin zero
	logic pin_one_o; // Host level on pin one
	logic pin_one_oe; // Host drives pin one
	wire general_pin_zero; // Resolved pin zero
	wire general_pin_one; // Resolved pin one

	// Undriven pin reads low
	assign general_pin_zero = pin_zero_oe & pin_zero_o;
	assign general_pin_one = pin_one_oe & pin_one_o;

	modport device (input reg_req, reg_wr, reg_addr, reg_wdata, general_pin_zero,
		general_pin_one, output reg_rdata, reg_ack);
	modport host (output reg_req, reg_wr, reg_addr, reg_wdata, pin_zero_o, pin_zero_oe,
		pin_one_o, pin_one_oe, input reg_rdata, reg_ack);
endinterface
`default_nettype wire

//--- core/pin_edge_sync.sv
// Three-stage pin synchroniser with agreed level and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic pin,
	output logic level,
	output logic rise
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] stg; // Sync chain
		logic lvl; // Agreed level
		logic rise; // Edge pulse
	} sync_state_t;
	sync_state_t st_reg;
	sync_state_t st_next;

	// Level moves only when stages two and three agree
	always_comb
	begin
		st_next = st_reg;
		st_next.stg = {st_reg.stg[1:0], pin};
		st_next.rise = 1'b0;
		if (st_reg.stg[1] == st_reg.stg[2])
		begin
			st_next.lvl = st_reg.stg[2];
			st_next.rise = st_reg.stg[2] & ~st_reg.lvl;
		end
	end

	// Register
	always_ff @(posedge clk)
	begin
		if (srst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign level = st_reg.lvl;
	assign rise = st_reg.rise;
endmodule
`default_nettype wire

//--- core/sample_sequencer_mode_control.sv
// Device end: configuration registers, sample clock, sync trigger, mode and slot sequencer
// Operation
// - bits 11:8 route second slot inputs
// - bits 7:4 route first slot inputs
// - code 0 leaves inputs floating
// - code 1 sums diodes ch1, externals ch2
// - code 5 maps ext1,ext2,pd1,pd2 to ch1-4
// - rate register and six-bit trim set clock
// - 32 kHz tick paces periods and sequencer
// - disabled slot skips pulse and processing
// - selected pin rising edge starts sampling
// - trigger waits one-two ticks, same start
// - host enables sync pin input buffer
// - host follows external sync setup order
// - clock select 2 takes pin one clock
// - host drives pin one before enabling
// - mode field 0 standby,1 program,2 normal
// - standby collects nothing, keeps registers
// - reset comes up in standby
// - host passes through program mode
// - program mode keeps circuitry powered
// - normal mode pulses and acquires each period
// - host writes recommended timing values
// - first slot runs before second slot
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sample_sequencer_mode_control (
	input wire logic clk,
	input wire logic srst,
	optseq_if.device link,
	output logic [1:0] mode_now,
	output logic period_start,
	output logic slot_a_active,
	output logic slot_b_active,
	output logic acquire,
	output logic powered,
	output logic [5:0] input_switch
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Route code to switch vector {pd2_ch4, pd1_ch3, ext2_ch2, ext1_ch1, ext_sum_ch2, pd_sum_ch1}
	function automatic logic [5:0] route_decode(input logic [3:0] code);
		case (code)
			optseq_pkg::ROUTE_FLOAT: route_decode = 6'h00;
			optseq_pkg::ROUTE_SUM: route_decode = 6'h03;
			optseq_pkg::ROUTE_SPLIT: route_decode = 6'h3c;
			default: route_decode = 6'h00; // Reserved codes float
		endcase
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] mode_r; // operating_mode_ctrl
		logic [15:0] rate_r; // sample_rate_setting
		logic [15:0] route_r; // input_route_select
		logic [15:0] pulse_a_r; // slot_a_pulse_timing
		logic [15:0] pulse_b_r; // slot_b_pulse_timing
		logic [15:0] trig_r; // trigger_config
		logic [15:0] win_a_r; // slot_a_frontend_window
		logic [15:0] win_b_r; // slot_b_frontend_window
		logic [15:0] osc_r; // oscillator_trim_select
		logic [15:0] pin_r; // pin_input_config
		logic ack; // Register answer
		logic [15:0] rdata; // Read data
		logic [12:0] div_cnt; // Internal tick divider
		logic [15:0] per_cnt; // Ticks into the period
		logic sync_pend; // Sync edge seen
		logic sync_arm; // First tick after edge passed
		optseq_pkg::seq_state_t seq; // Sequencer state
		logic [1:0] seq_cnt; // Ticks left in state
		logic [1:0] mode_o;
		logic start_o;
		logic sa_o;
		logic sb_o;
		logic acq_o;
		logic pwr_o;
		logic [5:0] sw_o;
	} dev_state_t;
	dev_state_t st_reg;
	dev_state_t st_next;

	logic pin0_rise; // Pin zero edge
	logic pin1_rise; // Pin one edge

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	pin_edge_sync u_sync_pin0 (
		.clk(clk),
		.srst(srst),
		.pin(link.general_pin_zero),
		.level(),
		.rise(pin0_rise)
	);
	pin_edge_sync u_sync_pin1 (
		.clk(clk),
		.srst(srst),
		.pin(link.general_pin_one),
		.level(),
		.rise(pin1_rise)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		logic [1:0] mode_eff;
		logic ext_clk;
		logic tick;
		logic [12:0] div_lim;
		logic [1:0] sync_sel;
		logic sync_edge;
		logic start;
		logic en_a;
		logic en_b;
		mode_eff = optseq_pkg::MODE_STANDBY;
		ext_clk = 1'b0;
		tick = 1'b0;
		div_lim = '0;
		sync_sel = '0;
		sync_edge = 1'b0;
		start = 1'b0;
		en_a = 1'b0;
		en_b = 1'b0;
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.start_o = 1'b0;

		// Register port: answer once per request
		if (link.reg_req && !st_reg.ack)
		begin
			st_next.ack = 1'b1;
			st_next.rdata = 16'h0000;
			case (link.reg_addr)
				optseq_pkg::ADDR_MODE: st_next.rdata = st_reg.mode_r;
				optseq_pkg::ADDR_RATE: st_next.rdata = st_reg.rate_r;
				optseq_pkg::ADDR_ROUTE: st_next.rdata = st_reg.route_r;
				optseq_pkg::ADDR_PULSE_A: st_next.rdata = st_reg.pulse_a_r;
				optseq_pkg::ADDR_PULSE_B: st_next.rdata = st_reg.pulse_b_r;
				optseq_pkg::ADDR_TRIG: st_next.rdata = st_reg.trig_r;
				optseq_pkg::ADDR_WIN_A: st_next.rdata = st_reg.win_a_r;
				optseq_pkg::ADDR_WIN_B: st_next.rdata = st_reg.win_b_r;
				optseq_pkg::ADDR_OSC: st_next.rdata = st_reg.osc_r;
				optseq_pkg::ADDR_PIN: st_next.rdata = st_reg.pin_r;
				default: st_next.rdata = 16'h0000;
			endcase
			if (link.reg_wr)
			begin
				case (link.reg_addr)
					optseq_pkg::ADDR_MODE: st_next.mode_r = link.reg_wdata;
					optseq_pkg::ADDR_RATE: st_next.rate_r = link.reg_wdata;
					optseq_pkg::ADDR_ROUTE: st_next.route_r = link.reg_wdata;
					optseq_pkg::ADDR_PULSE_A: st_next.pulse_a_r = link.reg_wdata;
					optseq_pkg::ADDR_PULSE_B: st_next.pulse_b_r = link.reg_wdata;
					optseq_pkg::ADDR_TRIG: st_next.trig_r = link.reg_wdata;
					optseq_pkg::ADDR_WIN_A: st_next.win_a_r = link.reg_wdata;
					optseq_pkg::ADDR_WIN_B: st_next.win_b_r = link.reg_wdata;
					optseq_pkg::ADDR_OSC: st_next.osc_r = link.reg_wdata;
					optseq_pkg::ADDR_PIN: st_next.pin_r = link.reg_wdata;
					default: ; // Unmapped writes dropped
				endcase
			end
		end

		case (st_reg.mode_r[optseq_pkg::MODE_LSB +: 2])
			optseq_pkg::MODE_PROGRAM: mode_eff = optseq_pkg::MODE_PROGRAM;
			optseq_pkg::MODE_NORMAL: mode_eff = optseq_pkg::MODE_NORMAL;
			default: mode_eff = optseq_pkg::MODE_STANDBY;
		endcase

		div_lim = optseq_pkg::SCLK_DIV_W + 13'(st_reg.osc_r[optseq_pkg::TRIM_LSB +: 6])
			- optseq_pkg::TRIM_MID;
		ext_clk = st_reg.osc_r[optseq_pkg::CLKSEL_LSB +: 2] == optseq_pkg::CLKSEL_EXT;
		if (ext_clk)
		begin
			st_next.div_cnt = '0;
			tick = pin1_rise
				& (st_reg.pin_r[optseq_pkg::PIN1_CFG_LSB +: 2] == optseq_pkg::PIN1_INPUT);
		end
		else if (st_reg.div_cnt >= div_lim - 13'h0001)
		begin
			st_next.div_cnt = '0;
			tick = 1'b1;
		end
		else
			st_next.div_cnt = st_reg.div_cnt + 13'h0001;

		// sync edge on the selected buffered pin
		sync_sel = st_reg.pin_r[optseq_pkg::SYNCSEL_LSB +: 2];
		sync_edge = (sync_sel == optseq_pkg::SYNC_PIN0 && st_reg.pin_r[optseq_pkg::PIN0_BUF_BIT]
			&& pin0_rise) || (sync_sel == optseq_pkg::SYNC_PIN1
			&& st_reg.pin_r[optseq_pkg::PIN1_CFG_LSB] && pin1_rise);

		// period timing advances on ticks only
		if (mode_eff != optseq_pkg::MODE_NORMAL)
		begin
			st_next.per_cnt = '0;
			st_next.sync_pend = 1'b0;
			st_next.sync_arm = 1'b0;
		end
		else if (sync_sel == optseq_pkg::SYNC_PIN0 || sync_sel == optseq_pkg::SYNC_PIN1)
		begin
			// one to two ticks of delay after the edge
			if (sync_edge)
				st_next.sync_pend = 1'b1;
			if (tick && st_reg.sync_pend)
			begin
				st_next.sync_arm = 1'b1;
				if (st_reg.sync_arm)
				begin
					start = 1'b1;
					st_next.sync_pend = sync_edge;
					st_next.sync_arm = 1'b0;
				end
			end
		end
		else if (tick)
		begin
			// rate register gives ticks per period
			if (st_reg.per_cnt + 16'h0001 >= st_reg.rate_r)
			begin
				st_next.per_cnt = '0;
				start = 1'b1;
			end
			else
				st_next.per_cnt = st_reg.per_cnt + 16'h0001;
		end

		// Sequencer
		en_a = st_reg.mode_r[optseq_pkg::SLOT_A_EN_BIT];
		en_b = st_reg.mode_r[optseq_pkg::SLOT_B_EN_BIT];
		if (mode_eff != optseq_pkg::MODE_NORMAL)
		begin
			st_next.seq = optseq_pkg::SEQ_SLEEP;
			st_next.seq_cnt = '0;
		end
		else if (tick)
		begin
			case (st_reg.seq)
				optseq_pkg::SEQ_SLEEP:
				begin
					if (start && en_a)
					begin
						st_next.seq = optseq_pkg::SEQ_SLOT_A;
						st_next.seq_cnt = optseq_pkg::SLOT_TICKS;
					end
					else if (start && en_b)
					begin
						st_next.seq = optseq_pkg::SEQ_SLOT_B;
						st_next.seq_cnt = optseq_pkg::SLOT_TICKS;
					end
				end
				optseq_pkg::SEQ_SLOT_A:
					if (st_reg.seq_cnt == 2'h1)
					begin
						st_next.seq = optseq_pkg::SEQ_PROC_A;
						st_next.seq_cnt = optseq_pkg::PROC_A_TICKS;
					end
					else
						st_next.seq_cnt = st_reg.seq_cnt - 2'h1;
				optseq_pkg::SEQ_PROC_A:
					if (st_reg.seq_cnt == 2'h1)
					begin
						st_next.seq = en_b ? optseq_pkg::SEQ_SLOT_B : optseq_pkg::SEQ_SLEEP;
						st_next.seq_cnt = optseq_pkg::SLOT_TICKS;
					end
					else
						st_next.seq_cnt = st_reg.seq_cnt - 2'h1;
				optseq_pkg::SEQ_SLOT_B:
					if (st_reg.seq_cnt == 2'h1)
					begin
						st_next.seq = optseq_pkg::SEQ_PROC_B;
						st_next.seq_cnt = optseq_pkg::PROC_B_TICKS;
					end
					else
						st_next.seq_cnt = st_reg.seq_cnt - 2'h1;
				optseq_pkg::SEQ_PROC_B:
					if (st_reg.seq_cnt == 2'h1)
						st_next.seq = optseq_pkg::SEQ_SLEEP;
					else
						st_next.seq_cnt = st_reg.seq_cnt - 2'h1;
				default: st_next.seq = optseq_pkg::SEQ_SLEEP;
			endcase
		end

		// Registered outputs
		st_next.mode_o = mode_eff;
		st_next.start_o = start && mode_eff == optseq_pkg::MODE_NORMAL && (en_a || en_b)
			&& st_reg.seq == optseq_pkg::SEQ_SLEEP;
		st_next.sa_o = st_next.seq == optseq_pkg::SEQ_SLOT_A;
		st_next.sb_o = st_next.seq == optseq_pkg::SEQ_SLOT_B;
		st_next.acq_o = st_next.sa_o | st_next.sb_o;
		st_next.pwr_o = mode_eff == optseq_pkg::MODE_PROGRAM
			|| st_next.seq != optseq_pkg::SEQ_SLEEP;
		if (st_next.sb_o)
			st_next.sw_o = route_decode(st_reg.route_r[optseq_pkg::ROUTE_B_LSB +: 4]);
		else if (st_next.sa_o)
			st_next.sw_o = route_decode(st_reg.route_r[optseq_pkg::ROUTE_A_LSB +: 4]);
		else
			st_next.sw_o = 6'h00;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_reg <= '0;
			st_reg.seq <= optseq_pkg::SEQ_SLEEP;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.reg_ack = st_reg.ack;
	assign link.reg_rdata = st_reg.rdata;
	assign mode_now = st_reg.mode_o;
	assign period_start = st_reg.start_o;
	assign slot_a_active = st_reg.sa_o;
	assign slot_b_active = st_reg.sb_o;
	assign acquire = st_reg.acq_o;
	assign powered = st_reg.pwr_o;
	assign input_switch = st_reg.sw_o;
endmodule
`default_nettype wire

//--- core/optseq_host.sv
// Host end: APB command registers, device register access, setup sequence and pin drivers
`timescale 1ns/1ps
`default_nettype none
module optseq_host (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	optseq_if.host link
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic busy; // Access or sequence running
		logic req; // Request to device
		logic wr;
		logic [7:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata; // Last read result
		logic seq_on; // Setup sequence running
		logic [3:0] step; // Setup step
		logic [31:0] pingen; // [0] gen on, [1] pin one, [31:16] half period
		logic [15:0] gen_cnt;
		logic gen_lvl;
		logic [31:0] prdata;
		logic pslverr;
	} host_state_t;
	host_state_t st_reg;
	host_state_t st_next;

	// ----------------------------------------
	// Setup step table
	// ----------------------------------------
	function automatic logic [23:0] setup_step(input logic [3:0] idx, input logic pin_one);
		case (idx)
			4'h0: setup_step = {optseq_pkg::ADDR_MODE, 14'h0000, optseq_pkg::MODE_PROGRAM};
			4'h1: setup_step = {optseq_pkg::ADDR_PIN, pin_one ? 16'h0028 : 16'h0006};
			4'h2: setup_step = {optseq_pkg::ADDR_TRIG, optseq_pkg::TRIG_EXT_SYNC};
			4'h3: setup_step = {optseq_pkg::ADDR_PULSE_A, optseq_pkg::PULSE_RECOMMEND};
			4'h4: setup_step = {optseq_pkg::ADDR_PULSE_B, optseq_pkg::PULSE_RECOMMEND};
			4'h5: setup_step = {optseq_pkg::ADDR_WIN_A, optseq_pkg::WINDOW_RECOMMEND};
			4'h6: setup_step = {optseq_pkg::ADDR_WIN_B, optseq_pkg::WINDOW_RECOMMEND};
			// normal mode last, both slots on
			4'h7: setup_step = {optseq_pkg::ADDR_MODE, 14'h0003, optseq_pkg::MODE_NORMAL};
			default: setup_step = 24'h000000;
		endcase
	endfunction

	// Next state
	always_comb
	begin
		logic access;
		logic [23:0] nxt;
		access = psel && penable;
		nxt = '0;
		st_next = st_reg;
		st_next.pslverr = 1'b0;

		// APB read data, zero wait
		case (paddr)
			optseq_pkg::APB_CMD: st_next.prdata = {st_reg.wdata, 7'h00, st_reg.wr, st_reg.addr};
			optseq_pkg::APB_STATUS: st_next.prdata = {st_reg.rdata, 15'h0000, st_reg.busy};
			optseq_pkg::APB_PINGEN: st_next.prdata = st_reg.pingen;
			default: st_next.prdata = 32'h00000000;
		endcase
		if (psel && !penable && paddr != optseq_pkg::APB_CMD && paddr != optseq_pkg::APB_STATUS
			&& paddr != optseq_pkg::APB_PINGEN)
			st_next.pslverr = 1'b1;

		// APB writes: command ignored while busy
		if (access && pwrite && paddr == optseq_pkg::APB_PINGEN)
			st_next.pingen = pwdata;
		if (access && pwrite && paddr == optseq_pkg::APB_CMD && !st_reg.busy)
		begin
			st_next.busy = 1'b1;
			if (pwdata[9])
			begin
				st_next.seq_on = 1'b1;
				nxt = setup_step(4'h0, st_reg.pingen[1]);
				st_next.step = 4'h1;
				{st_next.addr, st_next.wdata} = nxt;
				st_next.wr = 1'b1;
			end
			else
			begin
				st_next.addr = pwdata[7:0];
				st_next.wr = pwdata[8];
				st_next.wdata = pwdata[31:16];
			end
			st_next.req = 1'b1;
		end

		// Device answer ends one access
		if (st_reg.req && link.reg_ack)
		begin
			st_next.req = 1'b0;
			if (!st_reg.wr)
				st_next.rdata = link.reg_rdata;
			if (st_reg.seq_on && st_reg.step != optseq_pkg::SETUP_STEPS)
			begin
				nxt = setup_step(st_reg.step, st_reg.pingen[1]);
				{st_next.addr, st_next.wdata} = nxt;
				st_next.step = st_reg.step + 4'h1;
			end
			else
			begin
				st_next.busy = 1'b0;
				st_next.seq_on = 1'b0;
			end
		end
		// Next setup request two cycles after the answer
		if (st_reg.seq_on && st_reg.busy && !st_reg.req && !link.reg_ack)
			st_next.req = 1'b1;

		// Square wave on the chosen pin
		if (!st_reg.pingen[0])
		begin
			st_next.gen_cnt = '0;
			st_next.gen_lvl = 1'b0;
		end
		else if (st_reg.gen_cnt + 16'h0001 >= st_reg.pingen[31:16])
		begin
			st_next.gen_cnt = '0;
			st_next.gen_lvl = ~st_reg.gen_lvl;
		end
		else
			st_next.gen_cnt = st_reg.gen_cnt + 16'h0001;
	end

	// Register
	always_ff @(posedge clk)
	begin
		if (srst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = st_reg.prdata;
	assign pready = 1'b1;
	assign pslverr = st_reg.pslverr;
	assign link.reg_req = st_reg.req;
	assign link.reg_wr = st_reg.wr;
	assign link.reg_addr = st_reg.addr;
	assign link.reg_wdata = st_reg.wdata;
	// pins driven to a valid level from reset
	assign link.pin_zero_oe = 1'b1;
	assign link.pin_one_oe = 1'b1;
	assign link.pin_zero_o = st_reg.gen_lvl & ~st_reg.pingen[1];
	assign link.pin_one_o = st_reg.gen_lvl & st_reg.pingen[1];
endmodule
`default_nettype wire

//--- testbench/optseq_asserts.sv
// Checker of the register link and pin drivers between host and sequencer
`timescale 1ns/1ps
`default_nettype none
module optseq_asserts (
	input wire logic clk,
	input wire logic srst,
	input wire logic reg_req,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic pin_zero_oe,
	input wire logic pin_one_oe
);
	// All checks on the system clock
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	property p_ans; reg_req && !reg_ack |=> reg_ack; endproperty
	a_ans: assert property (p_ans) else $error("no ack");
	property p_one; reg_ack |=> !reg_ack; endproperty
	a_one: assert property (p_one) else $error("long ack");
	property p_drop; reg_ack |=> !reg_req; endproperty
	a_drop: assert property (p_drop) else $error("req kept");
	property p_hold; reg_req && !reg_ack |=> $stable({reg_wr, reg_addr, reg_wdata}); endproperty
	a_hold: assert property (p_hold) else $error("req moved");
	property p_cause; reg_ack |-> $past(reg_req); endproperty
	a_cause: assert property (p_cause) else $error("stray ack");
	property p_idle; !reg_req |=> !reg_ack; endproperty
	a_idle: assert property (p_idle) else $error("idle ack");
	property p_rd; $changed(reg_rdata) |-> reg_ack; endproperty
	a_rd: assert property (p_rd) else $error("rdata moved");
	property p_oe; pin_zero_oe && pin_one_oe; endproperty
	a_oe: assert property (p_oe) else $error("pin undriven");
	cover property (reg_ack && reg_wr);
	cover property (reg_ack && !reg_wr);
	cover property (reg_ack ##[1:8] reg_req);
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Testbench joining host and sequencer ends over the register link
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] mode_now, m;
	logic period_start, slot_a_active, slot_b_active, acquire, powered;
	logic [5:0] input_switch;
	int errors = 0, n_compared = 0, cyc = 0;
	optseq_if link ();
	sample_sequencer_mode_control sample_sequencer_mode_control_inst (.clk, .srst, .link,
		.mode_now, .period_start, .slot_a_active, .slot_b_active, .acquire, .powered,
		.input_switch);
	optseq_host optseq_host_inst (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .link);
	optseq_asserts optseq_asserts_inst (.clk, .srst, .reg_req(link.reg_req),
		.reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .pin_zero_oe(link.pin_zero_oe),
		.pin_one_oe(link.pin_one_oe));
	// Compare and count
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer, read data kept in rd
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Device register access through the host, waits while busy
	task dev(input logic [7:0] a, input logic [15:0] d, input logic w = 1'b1);
		apb(1'b1, optseq_pkg::APB_CMD, {d, 7'h00, w, a});
		do apb(1'b0, optseq_pkg::APB_STATUS, 32'h0); while (rd[0] !== 1'b0);
	endtask
	// One sampling period: slot order and switch settings
	task slots(input logic a_on, input logic [5:0] sa, input logic [5:0] sb);
		for (int i = 0; i < 900 && period_start !== 1'b1; i++) @(negedge clk);
		for (int i = 0; i < 99 && acquire !== 1'b1; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		chk("first slot", 16'(slot_a_active), 16'(a_on));
		if (a_on) chk("order", 16'(slot_b_active), 16'h0000);
		if (a_on) chk("first route", 16'(input_switch), 16'(sa));
		for (int i = 0; i < 200 && slot_b_active !== 1'b1; i++) @(negedge clk);
		repeat (2) @(negedge clk);
		chk("second route", 16'(input_switch), 16'(sb));
		chk("acquire", 16'(acquire), 16'h0001);
	endtask
	task t_reset;
		chk("reset mode", 16'(mode_now), 16'h0000);
		dev(optseq_pkg::ADDR_MODE, 16'h0000, 1'b0);
		chk("mode reg", rd[31:16], 16'h0000);
		// Unmapped host offset answers with an error and zero data
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 16'({perr, |rd}), 16'h0002);
		$display("reset test done");
	endtask
	task t_modes;
		dev(optseq_pkg::ADDR_MODE, 16'h0001);
		dev(optseq_pkg::ADDR_ROUTE, 16'h0150);
		for (int i = 0; i < 6; i++)
		begin
			m = 2'(12'h674 >> (10 - 2 * i));
			dev(optseq_pkg::ADDR_MODE, 16'(m));
			@(negedge clk);
			chk("mode", 16'(mode_now), (m == 2'h3) ? 16'h0000 : 16'(m));
			if (m == 2'h1) chk("powered", 16'(powered), 16'h0001);
		end
		chk("standby", 16'({powered, acquire}), 16'h0000);
		dev(optseq_pkg::ADDR_ROUTE, 16'h0000, 1'b0);
		chk("route kept", rd[31:16], 16'h0150);
		$display("mode test done");
	endtask
	task t_ext;
		// Pin one clock driven before the pin is enabled
		apb(1'b1, optseq_pkg::APB_PINGEN, 32'h0008_0003);
		dev(optseq_pkg::ADDR_MODE, 16'h0001);
		dev(optseq_pkg::ADDR_PIN, 16'h0020);
		dev(optseq_pkg::ADDR_OSC, 16'h0100);
		dev(optseq_pkg::ADDR_MODE, 16'h000e);
		slots(1'b1, 6'h3c, 6'h03);
		dev(optseq_pkg::ADDR_MODE, 16'h0001);
		dev(optseq_pkg::ADDR_ROUTE, 16'h0050);
		dev(optseq_pkg::ADDR_MODE, 16'h000a);
		slots(1'b0, 6'h00, 6'h00);
		$display("slot test done");
	endtask
	// Host setup sequence, then a square wave on pin zero as sync source
	task t_sync;
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		// back to the internal tick at mid trim
		dev(optseq_pkg::ADDR_MODE, 16'h0001);
		dev(optseq_pkg::ADDR_OSC, 16'h0020);
		apb(1'b1, optseq_pkg::APB_PINGEN, 32'h0008_0000);
		apb(1'b1, optseq_pkg::APB_CMD, 32'h0000_0200);
		do apb(1'b0, optseq_pkg::APB_STATUS, 32'h0); while (rd[0] !== 1'b0);
		dev(optseq_pkg::ADDR_TRIG, 16'h0000, 1'b0);
		chk("trigger", rd[31:16], optseq_pkg::TRIG_EXT_SYNC);
		dev(optseq_pkg::ADDR_PIN, 16'h0000, 1'b0);
		chk("pin cfg", rd[31:16], 16'h0006);
		dev(optseq_pkg::ADDR_PULSE_B, 16'h0000, 1'b0);
		chk("pulse", rd[31:16], optseq_pkg::PULSE_RECOMMEND);
		dev(optseq_pkg::ADDR_MODE, 16'h0000, 1'b0);
		chk("setup mode", rd[31:16], 16'h000e);
		// First rising edge on pin zero launches one period
		apb(1'b1, optseq_pkg::APB_PINGEN, 32'h0008_0001);
		while (period_start !== 1'b1 && n < 8000)
		begin
			@(negedge clk);
			n++;
		end
		ok = n > optseq_pkg::SCLK_DIV && n < 2 * optseq_pkg::SCLK_DIV + 40;
		chk("sync delay", 16'(ok), 16'h0001);
		@(negedge clk);
		chk("sync slot", 16'(slot_a_active), 16'h0001);
		$display("sync test done");
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			tally_and_finish;
		end
	end
	initial
	begin
		{srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_modes;
		t_ext;
		t_sync;
		tally_and_finish;
	end
endmodule
`default_nettype wire
